/* File: verilog/pmx_pin_mux.sv */
/*
 * Multipurpose pin multiplexer: direction, output source and software
 * level registers for three pins, and routing of pin levels to the
 * serial-flash data input, ramp phase sync, reset and mute inputs.
 * Assumes an 8-bit register port on clk_sys with one-cycle read
 * latency, internal sources synchronous to clk_sys, and pads resolved
 * outside from pad_out and pad_oe.
 */
// What this block does
// (RQ1) Bits 2..0 of direction register set each pin: 0 input, 1 output.
// (RQ2) Direction register resets to zero, so all pins start as inputs.
// (RQ3) Source code 0000 drives low; 0010 drives the software level.
// (RQ4) Code 0011 outputs auto-mute, high only when both channels muted.
// (RQ5) Code 0100 outputs left auto-mute, 0101 right auto-mute.
// (RQ6) Code 0110 outputs the clock-invalid flag.
// (RQ7) Code 1000 outputs the active-low warning.
// (RQ8) Code 1001 outputs serial audio data out.
// (RQ9) Code 1011 outputs the active-low fault.
// (RQ10) Code 1100 outputs serial-flash clock, 1101 its MOSI data.
// (RQ11) Pins 1 and 2 have own selectors in bits 3..0, same codes.
// (RQ12) Routing bits 7-6 pick MISO pin, 5-4 phase sync pin.
// (RQ13) Bits 3-2 pick reset pin; this register ignores that reset.
// (RQ14) Bits 1-0 pick mute pin; low mute forces output stage hi-Z.
// (RQ15) Software level register bits 2..0 give each pin's level.
// (RQ16) Code 1010 and reserved codes drive the pin low.
// (RQ17) Input pins never drive; their level feeds the routing.
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_mux (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] pad_in,
	output logic [2:0] pad_out,
	output logic [2:0] pad_oe,
	input wire logic auto_mute_left,
	input wire logic auto_mute_right,
	input wire logic clock_invalid,
	input wire logic warning_out_n,
	input wire logic fault_out_n,
	input wire logic audio_serial_data_out,
	input wire logic spi_clk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic ramp_phase_sync,
	output logic pin_reset_n,
	output logic mute_in_n,
	output logic output_stage_hiz
);

	// ========================================================
	// State
	typedef struct packed {
		logic [7:0] pin_direction;
		logic [7:0] pin0_output_source;
		logic [7:0] pin1_output_source;
		logic [7:0] pin2_output_source;
		logic [7:0] input_routing;
		logic [7:0] software_pin_levels;
		logic [7:0] rdata;
		logic miso;
		logic phase_sync;
		logic reset_n;
		logic mute_n;
		logic stage_hiz;
	} pmx_state_t;

	pmx_state_t st;
	pmx_state_t next_st;

	logic [2:0] pad_level;
	logic [2:0] drive_enable;
	logic [2:0][3:0] source_code;
	logic [2:0] sw_level;
	pmx_pkg::pmx_pick_t miso_pick;
	pmx_pkg::pmx_pick_t sync_pick;
	pmx_pkg::pmx_pick_t reset_in_pin_pick;
	pmx_pkg::pmx_pick_t mute_in_pin_pick;

	// ========================================================
	// Pad input synchroniser
	// Pads are asynchronous; routing only ever sees the resynced level.
	pmx_sync #(
		.WIDTH(pmx_pkg::PIN_COUNT)
	) u_pad_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in(pad_in),
		.sync_out(pad_level)
	);

	// ========================================================
	// Field extraction
	always_comb begin
		drive_enable = st.pin_direction[2:0]; // RQ1
		source_code[0] = st.pin0_output_source[pmx_pkg::SOURCE_CODE_MSB:pmx_pkg::SOURCE_CODE_LSB];
		source_code[1] = st.pin1_output_source[pmx_pkg::SOURCE_CODE_MSB:pmx_pkg::SOURCE_CODE_LSB]; // RQ11
		source_code[2] = st.pin2_output_source[pmx_pkg::SOURCE_CODE_MSB:pmx_pkg::SOURCE_CODE_LSB]; // RQ11
		sw_level = st.software_pin_levels[2:0]; // RQ15
		miso_pick = pmx_pkg::pmx_pick_t'(st.input_routing[pmx_pkg::MISO_PICK_LSB +: 2]); // RQ12
		sync_pick = pmx_pkg::pmx_pick_t'(st.input_routing[pmx_pkg::SYNC_PICK_LSB +: 2]); // RQ12
		reset_in_pin_pick = pmx_pkg::pmx_pick_t'(st.input_routing[pmx_pkg::RESET_PICK_LSB +: 2]);
		mute_in_pin_pick = pmx_pkg::pmx_pick_t'(st.input_routing[pmx_pkg::MUTE_PICK_LSB +: 2]);
	end

	// ========================================================
	// Per-pin output drivers
	genvar gi;
	generate
		for (gi = 0; gi < pmx_pkg::PIN_COUNT; gi++) begin : g_pin
			pmx_pin_drive u_drive (
				.clk_sys(clk_sys),
				.rst(rst),
				.drive_enable(drive_enable[gi]),
				.source_code(source_code[gi]),
				.sw_level(sw_level[gi]),
				.auto_mute_left(auto_mute_left),
				.auto_mute_right(auto_mute_right),
				.clock_invalid(clock_invalid),
				.warning_out_n(warning_out_n),
				.fault_out_n(fault_out_n),
				.audio_serial_data_out(audio_serial_data_out),
				.spi_clk(spi_clk),
				.spi_mosi(spi_mosi),
				.pad_out(pad_out[gi]),
				.pad_oe(pad_oe[gi])
			);
		end
	endgenerate

	// ========================================================
	// Input routing helper
	// Routes the pad level even while that pin drives, so a driven pin
	// simply loops its own output back.
	function automatic logic pick_level(
		input pmx_pkg::pmx_pick_t pick,
		input logic [2:0] levels,
		input logic idle
	);
		logic result;
		result = idle;
		case (pick)
			pmx_pkg::PICK_NONE: result = idle;
			pmx_pkg::PICK_PIN0: result = levels[0];
			pmx_pkg::PICK_PIN1: result = levels[1];
			pmx_pkg::PICK_PIN2: result = levels[2];
			default: result = idle;
		endcase
		return result;
	endfunction

	// ========================================================
	// Next state
	always_comb begin
		next_st = st;

		// Register writes; full byte stored, reserved bits read back
		if (reg_wr) begin
			case (reg_addr)
				pmx_pkg::OFF_PIN_DIRECTION: begin
					next_st.pin_direction = reg_wdata; // RQ1
				end
				pmx_pkg::OFF_PIN0_SOURCE: begin
					next_st.pin0_output_source = reg_wdata;
				end
				pmx_pkg::OFF_PIN1_SOURCE: begin
					next_st.pin1_output_source = reg_wdata; // RQ11
				end
				pmx_pkg::OFF_PIN2_SOURCE: begin
					next_st.pin2_output_source = reg_wdata; // RQ11
				end
				pmx_pkg::OFF_INPUT_ROUTING: begin
					next_st.input_routing = reg_wdata; // RQ12
				end
				pmx_pkg::OFF_SW_PIN_LEVELS: begin
					next_st.software_pin_levels = reg_wdata; // RQ15
				end
				default: begin
					next_st.pin_direction = st.pin_direction;
				end
			endcase
		end

		// Register reads, answered one cycle later and held
		if (reg_rd) begin
			case (reg_addr)
				pmx_pkg::OFF_PIN_DIRECTION: begin
					next_st.rdata = st.pin_direction;
				end
				pmx_pkg::OFF_PIN0_SOURCE: begin
					next_st.rdata = st.pin0_output_source;
				end
				pmx_pkg::OFF_PIN1_SOURCE: begin
					next_st.rdata = st.pin1_output_source;
				end
				pmx_pkg::OFF_PIN2_SOURCE: begin
					next_st.rdata = st.pin2_output_source;
				end
				pmx_pkg::OFF_INPUT_ROUTING: begin
					next_st.rdata = st.input_routing;
				end
				pmx_pkg::OFF_SW_PIN_LEVELS: begin
					next_st.rdata = st.software_pin_levels;
				end
				default: begin
					next_st.rdata = pmx_pkg::RDATA_UNMAPPED;
				end
			endcase
		end

		// Routed inputs
		next_st.miso = pick_level(miso_pick, pad_level, pmx_pkg::IDLE_MISO); // RQ12
		next_st.phase_sync = pick_level(sync_pick, pad_level, pmx_pkg::IDLE_SYNC); // RQ12
		next_st.reset_n = pick_level(reset_in_pin_pick, pad_level, pmx_pkg::IDLE_RESET_N); // RQ13
		next_st.mute_n = pick_level(mute_in_pin_pick, pad_level, pmx_pkg::IDLE_MUTE_N); // RQ14
		next_st.stage_hiz = ~next_st.mute_n; // RQ14
	end

	// ========================================================
	// State register
	// Only rst clears the registers; pin_reset_n leaves for the rest of
	// the device and never loops back here.
	always_ff @(posedge clk_sys) begin
		if (rst) begin // RQ13
			st.pin_direction <= pmx_pkg::RST_PIN_DIRECTION; // RQ2
			st.pin0_output_source <= pmx_pkg::RST_PIN_SOURCE;
			st.pin1_output_source <= pmx_pkg::RST_PIN_SOURCE;
			st.pin2_output_source <= pmx_pkg::RST_PIN_SOURCE;
			st.input_routing <= pmx_pkg::RST_INPUT_ROUTING;
			st.software_pin_levels <= pmx_pkg::RST_SW_PIN_LEVELS;
			st.rdata <= pmx_pkg::RDATA_UNMAPPED;
			st.miso <= pmx_pkg::IDLE_MISO;
			st.phase_sync <= pmx_pkg::IDLE_SYNC;
			st.reset_n <= pmx_pkg::IDLE_RESET_N;
			st.mute_n <= pmx_pkg::IDLE_MUTE_N;
			st.stage_hiz <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ========================================================
	// Outputs
	assign reg_rdata = st.rdata;
	assign spi_miso = st.miso;
	assign ramp_phase_sync = st.phase_sync;
	assign pin_reset_n = st.reset_n;
	assign mute_in_n = st.mute_n;
	assign output_stage_hiz = st.stage_hiz;

endmodule

`default_nettype wire

/* File: verilog/pmx_pkg.sv */
/*
 * Constants and types for the multipurpose pin multiplexer: register
 * offsets, reset values, field positions, output source codes and the
 * input pin pick encoding.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
`default_nettype none

package pmx_pkg;

	// ========================================================
	// Register offsets
	localparam logic [7:0] OFF_PIN_DIRECTION = 8'h60;
	localparam logic [7:0] OFF_PIN0_SOURCE = 8'h61;
	localparam logic [7:0] OFF_PIN1_SOURCE = 8'h62;
	localparam logic [7:0] OFF_PIN2_SOURCE = 8'h63;
	localparam logic [7:0] OFF_INPUT_ROUTING = 8'h64;
	localparam logic [7:0] OFF_SW_PIN_LEVELS = 8'h65;

	// ========================================================
	// Reset values
	localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
	localparam logic [7:0] RST_PIN_SOURCE = 8'h00;
	localparam logic [7:0] RST_INPUT_ROUTING = 8'h00;
	localparam logic [7:0] RST_SW_PIN_LEVELS = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// ========================================================
	// Field positions
	localparam int PIN_COUNT = 3;
	localparam int SOURCE_CODE_LSB = 0;
	localparam int SOURCE_CODE_MSB = 3;
	localparam int MISO_PICK_LSB = 6;
	localparam int SYNC_PICK_LSB = 4;
	localparam int RESET_PICK_LSB = 2;
	localparam int MUTE_PICK_LSB = 0;

	// ========================================================
	// Output source codes
	localparam logic [3:0] SRC_LOW = 4'h0;
	localparam logic [3:0] SRC_SW_LEVEL = 4'h2;
	localparam logic [3:0] SRC_MUTE_BOTH = 4'h3;
	localparam logic [3:0] SRC_MUTE_LEFT = 4'h4;
	localparam logic [3:0] SRC_MUTE_RIGHT = 4'h5;
	localparam logic [3:0] SRC_CLOCK_INVALID = 4'h6;
	localparam logic [3:0] SRC_WARNING_N = 4'h8;
	localparam logic [3:0] SRC_AUDIO_AUDIO_SERIAL_DATA_OUT = 4'h9;
	localparam logic [3:0] SRC_FAULT_N = 4'hb;
	localparam logic [3:0] SRC_SPI_CLK = 4'hc;
	localparam logic [3:0] SRC_SPI_MOSI = 4'hd;

	// ========================================================
	// Input pin pick encoding
	typedef enum logic [1:0] {
		PICK_NONE = 2'b00,
		PICK_PIN0 = 2'b01,
		PICK_PIN1 = 2'b10,
		PICK_PIN2 = 2'b11
	} pmx_pick_t;

	// Levels seen by routed inputs when no pin is picked
	localparam logic IDLE_MISO = 1'b0;
	localparam logic IDLE_SYNC = 1'b0;
	localparam logic IDLE_RESET_N = 1'b1;
	localparam logic IDLE_MUTE_N = 1'b1;

endpackage

`default_nettype wire

/* File: verilog/pmx_sync.sv */
/*
 * Two flip-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes each bit is an independent level; no multi-bit coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module pmx_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pmx_sync_state_t;

	pmx_sync_state_t st;
	pmx_sync_state_t next_st;

	// ========================================================
	// Stage one feeds only stage two
	always_comb begin
		next_st = st;
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;

endmodule

`default_nettype wire

/* File: verilog/pmx_pin_drive.sv */
/*
 * Output source selector and driver for one multipurpose pin.
 * Assumes all sources are levels from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_drive (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic drive_enable,
	input wire logic [3:0] source_code,
	input wire logic sw_level,
	input wire logic auto_mute_left,
	input wire logic auto_mute_right,
	input wire logic clock_invalid,
	input wire logic warning_out_n,
	input wire logic fault_out_n,
	input wire logic audio_serial_data_out,
	input wire logic spi_clk,
	input wire logic spi_mosi,
	output logic pad_out,
	output logic pad_oe
);

	typedef struct packed {
		logic level;
		logic oe;
	} pmx_drive_state_t;

	pmx_drive_state_t st;
	pmx_drive_state_t next_st;

	// ========================================================
	// Source selection
	always_comb begin
		next_st = st;
		next_st.oe = drive_enable; // RQ17
		case (source_code)
			pmx_pkg::SRC_LOW: next_st.level = 1'b0; // RQ3
			pmx_pkg::SRC_SW_LEVEL: next_st.level = sw_level; // RQ3
			pmx_pkg::SRC_MUTE_BOTH: next_st.level = auto_mute_left & auto_mute_right; // RQ4
			pmx_pkg::SRC_MUTE_LEFT: next_st.level = auto_mute_left; // RQ5
			pmx_pkg::SRC_MUTE_RIGHT: next_st.level = auto_mute_right; // RQ5
			pmx_pkg::SRC_CLOCK_INVALID: next_st.level = clock_invalid; // RQ6
			pmx_pkg::SRC_WARNING_N: next_st.level = warning_out_n; // RQ7
			pmx_pkg::SRC_AUDIO_AUDIO_SERIAL_DATA_OUT: next_st.level = audio_serial_data_out; // RQ8
			pmx_pkg::SRC_FAULT_N: next_st.level = fault_out_n; // RQ9
			pmx_pkg::SRC_SPI_CLK: next_st.level = spi_clk; // RQ10
			pmx_pkg::SRC_SPI_MOSI: next_st.level = spi_mosi; // RQ10
			default: next_st.level = 1'b0; // RQ16
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pad_out = st.level;
	assign pad_oe = st.oe;

endmodule

`default_nettype wire

/* File: tb/pmx_pin_mux_assertions.sv */
/*
 * Port timing checker for pmx_pin_mux.
 * Assumes it is bound onto pmx_pin_mux from the bench top file.
 */
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_mux_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] pad_in,
	input wire logic [2:0] pad_out,
	input wire logic [2:0] pad_oe,
	input wire logic auto_mute_left,
	input wire logic spi_miso,
	input wire logic pin_reset_n,
	input wire logic mute_in_n,
	input wire logic output_stage_hiz
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ========================================================
	// Register effects
	AST_RESET: assert property (disable iff (1'b0)
		rst |=> pad_oe == 3'h0 && reg_rdata == 8'h00 && mute_in_n && pin_reset_n)
		else $error("reset state wrong");
	AST_OE_DIR: assert property (
		reg_wr && reg_addr == 8'h60 ##1 !(reg_wr && reg_addr == 8'h60)
		|=> pad_oe == $past(reg_wdata[2:0], 2))
		else $error("pad_oe does not follow direction write");
	AST_READBACK: assert property (
		reg_wr && reg_addr == 8'h60 ##1 reg_rd && !reg_wr && reg_addr == 8'h60
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("direction read back wrong");
	AST_LOW_CODE: assert property (
		reg_wr && reg_addr == 8'h61 && reg_wdata[3:0] inside {4'h0, 4'h1, 4'h7, 4'ha, 4'he, 4'hf}
		##1 !(reg_wr && reg_addr == 8'h61) |=> !pad_out[0])
		else $error("low or reserved code not low");
	AST_LEFT_PIN2: assert property (
		reg_wr && reg_addr == 8'h63 && reg_wdata[3:0] == 4'h4
		##1 !(reg_wr && reg_addr == 8'h63) [*2] |-> pad_out[2] == $past(auto_mute_left))
		else $error("pin2 left mute flag wrong");

	// ========================================================
	// Input routing
	AST_HIZ: assert property (output_stage_hiz == !mute_in_n)
		else $error("hiz not tied to mute");
	AST_MUTE_ROUTE: assert property ($fell(mute_in_n) |-> $past(pad_in, 3) != 3'h7)
		else $error("mute fell without low pin");
	AST_RESET_ROUTE: assert property ($fell(pin_reset_n) |-> $past(pad_in, 3) != 3'h7)
		else $error("reset fell without low pin");
	AST_MISO: assert property ($rose(spi_miso) |-> $past(pad_in, 3) != 3'h0)
		else $error("miso rose without high pin");
endmodule

`default_nettype wire

/* File: tb/pmx_pad_model.sv */
/*
 * Outside circuits on the three pins.
 * Assumes the bench sets the level each circuit drives.
 */
`timescale 1ns/1ps
`default_nettype none

module pmx_pad_model (
	input wire logic [2:0] pad_out,
	input wire logic [2:0] pad_oe,
	input wire logic [2:0] ext_level,
	output logic [2:0] pad_in
);
	// Device wins where it drives; weak outside source elsewhere
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
		end
	end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for pmx_pin_mux against a register model.
 * Assumes pmx_pkg, the design, the pad model and checker compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [2:0] pad_in, pad_out, pad_oe;
	logic [2:0] ext_level = 3'h7;
	// Sources: left, right, clkinv, warn_n, fault_n, audio_serial_data_out, spiclk, mosi
	logic [7:0] src = 8'h00;
	logic spi_miso, ramp_phase_sync, pin_reset_n, mute_in_n, output_stage_hiz;
	logic [7:0] regs [6] = '{default: 8'h00};
	int n_errors = 0;
	int comparisons = 0;
	int seed = 80;

	always #25 clk_sys = ~clk_sys;

	pmx_pin_mux pmx_pin_mux_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .auto_mute_left(src[0]),
		.auto_mute_right(src[1]), .clock_invalid(src[2]), .warning_out_n(src[3]),
		.fault_out_n(src[4]), .audio_serial_data_out(src[5]), .spi_clk(src[6]),
		.spi_mosi(src[7]), .spi_miso(spi_miso), .ramp_phase_sync(ramp_phase_sync),
		.pin_reset_n(pin_reset_n), .mute_in_n(mute_in_n), .output_stage_hiz(output_stage_hiz));

	pmx_pad_model pmx_pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe),
		.ext_level(ext_level), .pad_in(pad_in));

	// ========================================================
	// Model and helpers
	function automatic int xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic exp_out(input logic [3:0] c, input int p);
		case (c)
			4'h2: return regs[5][p];
			4'h3: return src[0] & src[1];
			4'h4: return src[0];
			4'h5: return src[1];
			4'h6: return src[2];
			4'h8: return src[3];
			4'h9: return src[5];
			4'hb: return src[4];
			4'hc: return src[6];
			4'hd: return src[7];
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic rt(input int sh, input logic idle);
		int pk;
		pk = (regs[4] >> sh) & 3;
		return (pk == 0) ? idle : ext_level[pk - 1];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a >= 8'h60 && a <= 8'h65) regs[a - 8'h60] = d;
	endtask

	// Now set: read taken at the edge right after a write
	task automatic rd(input logic [7:0] a, input bit now = 1'b0);
		if (!now) @(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, (a >= 8'h60 && a <= 8'h65) ? regs[a - 8'h60] : 8'h00);
	endtask

	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ========================================================
	// Scenarios
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 8'h5f; a <= 8'h66; a++) rd(a[7:0]);
		$display("test reset values done");
		for (int a = 8'h5f; a <= 8'h66; a++) begin
			wr(a[7:0], 8'(xs()));
			rd(a[7:0], 1'b1);
		end
		$display("test register access done");
		for (int d = 0; d < 8; d++) begin
			wr(8'h60, d[7:0]);
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk({5'h0, pad_oe}, d[7:0]);
		end
		$display("test direction done");
		for (int p = 0; p < 3; p++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge clk_sys);
				src <= 8'(xs());
				wr(8'h65, 8'(xs()));
				wr(8'(8'h61 + p), {4'(xs()), c[3:0]});
				repeat (2) @(posedge clk_sys);
				@(negedge clk_sys);
				chk({7'h0, pad_out[p]}, {7'h0, exp_out(c[3:0], p)});
			end
		end
		$display("test output sources done");
		wr(8'h60, 8'h00);
		for (int f = 0; f < 4; f++) begin
			for (int k = 0; k < 4; k++) begin
				wr(8'h64, 8'(k << (2 * f)));
				repeat (2) begin
					@(posedge clk_sys);
					ext_level <= 3'(xs());
					repeat (4) @(posedge clk_sys);
					@(negedge clk_sys);
					chk({3'h0, spi_miso, ramp_phase_sync, pin_reset_n, mute_in_n, output_stage_hiz},
						{3'h0, rt(6, 1'b0), rt(4, 1'b0), rt(2, 1'b1), rt(0, 1'b1), ~rt(0, 1'b1)});
				end
				rd(8'h64);
			end
		end
		$display("test input routing done");
		end_sim();
	end
endmodule

bind pmx_pin_mux pmx_pin_mux_chk pmx_pin_mux_chk_inst (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
	.auto_mute_left(auto_mute_left), .spi_miso(spi_miso), .pin_reset_n(pin_reset_n),
	.mute_in_n(mute_in_n), .output_stage_hiz(output_stage_hiz));

`default_nettype wire
